// [hw/dly_seq.sv]
// The implementer's own choices: the strobed register port and the placing of the registers.
module dly_seq (
	input  wire logic                clock,
	input  wire logic                rst_b,
	input  wire logic [31:0]         samples,
	input  wire logic [7:0]          addr,
	input  wire logic [31:0]         wr_data,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output logic      [31:0]         rd_data,
	output logic                     acquiring,
	output logic                     record_done,
	output logic      [31:0]         zone_start,
	output logic      [31:0]         zone_end,
	output logic                     main_bar_on,
	output logic                     dly_bar_on,
	output logic      [7:0]          main_bar_level,
	output logic      [7:0]          dly_bar_level
);

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [31:0]                 ctrl_reg;
	logic [31:0]                 delay_reg;
	logic [15:0]                 events_reg;
	logic [31:0]                 thresh_reg;
	dly_seq_pkg::trig_cfg_t      mcfg_reg;
	dly_seq_pkg::trig_cfg_t      dcfg_reg;
	logic [4:0]                  post_reg;
	logic [3:0]                  ridx_reg;
	logic                        done_reg;
	logic [31:0]                 samp_s1_reg;
	logic [31:0]                 samp_s2_reg;
	logic [3:0]                  lvl_reg;
	logic [3:0]                  prev_reg;
	logic [3:0]                  mem_reg  [dly_seq_pkg::REC_DEPTH];
	logic [3:0]                  disp_reg [dly_seq_pkg::REC_DEPTH];
	logic [3:0]                  wp_reg;
	logic [3:0]                  trig_idx_reg;
	logic [3:0]                  shown_idx_reg;
	logic [31:0]                 tcnt_reg;
	logic [15:0]                 ecnt_reg;
	logic [4:0]                  pcnt_reg;
	dly_seq_pkg::seq_state_t     state_reg;
	dly_seq_pkg::seq_state_t     state_next;
	logic [3:0]                  lvl_next;
	logic                        main_hit;
	logic                        dly_hit;
	logic                        time_up;
	logic                        evts_up;
	logic                        post_up;
	logic                        mode;
	logic [1:0]                  sub;

	assign mode    = ctrl_reg[dly_seq_pkg::CTRL_MODE];
	assign sub     = ctrl_reg[dly_seq_pkg::CTRL_SUB +: 2];
	assign time_up = (tcnt_reg + 32'h1) >= delay_reg;
	assign evts_up = dly_hit && ((ecnt_reg + 16'h1) >= events_reg);
	assign post_up = (pcnt_reg + 5'h1) >= post_reg;

	// ----------------------------------------------------------------
	// Trigger evaluation
	// ----------------------------------------------------------------
	// Shared by both systems; each passes its own type and settings.
	function automatic logic trig_eval(input logic [2:0] ty,
		input dly_seq_pkg::trig_cfg_t c, input logic [3:0] now, input logic [3:0] prv);
		logic s_now;
		logic s_prv;
		logic match;
		logic was;
		s_now = now[c.source];
		s_prv = prv[c.source];
		match = ((now ^ c.pattern) & c.mask) == 4'h0;
		was   = ((prv ^ c.pattern) & c.mask) == 4'h0;
		unique case (ty)
			dly_seq_pkg::TT_EDGE:    trig_eval = (s_now != s_prv) && (s_now == c.slope);
			dly_seq_pkg::TT_PULSE:   trig_eval = (s_prv == c.polarity) && (s_now != c.polarity);
			dly_seq_pkg::TT_PATTERN: trig_eval = match && !was;
			dly_seq_pkg::TT_STATE:   trig_eval = s_now && !s_prv && match;
			dly_seq_pkg::TT_SEQ:     trig_eval = was && (s_now != s_prv) && (s_now == c.slope);
			default:                 trig_eval = 1'b0;
		endcase
	endfunction

	assign main_hit = trig_eval(ctrl_reg[dly_seq_pkg::CTRL_MTYPE +: 3], mcfg_reg,
		lvl_reg, prev_reg); // [R9] [R11]
	assign dly_hit  = trig_eval(ctrl_reg[dly_seq_pkg::CTRL_DTYPE +: 3], dcfg_reg,
		lvl_reg, prev_reg); // [R9] [R11]

	// ----------------------------------------------------------------
	// Input sampling
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			samp_s1_reg <= 32'h0;
			samp_s2_reg <= 32'h0;
		end else begin
			samp_s1_reg <= samples;
			samp_s2_reg <= samp_s1_reg;
		end
	end

	// Each source is compared with its single threshold, used by both systems.
	for (genvar i = 0; i < dly_seq_pkg::N_SRC; i++) begin : g_cmp
		assign lvl_next[i] = samp_s2_reg[i*8 +: 8] >= thresh_reg[i*8 +: 8]; // [R10]
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lvl_reg  <= 4'h0;
			prev_reg <= 4'h0;
		end else begin
			lvl_reg  <= lvl_next;
			prev_reg <= lvl_reg;
		end
	end

	// Ring buffer never stops, so the pretrigger part is always full.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wp_reg <= 4'h0;
			for (int k = 0; k < dly_seq_pkg::REC_DEPTH; k++) mem_reg[k] <= 4'h0;
		end else begin
			wp_reg          <= wp_reg + 4'h1; // [R7]
			mem_reg[wp_reg] <= lvl_reg;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			dly_seq_pkg::ST_IDLE: begin
				if (ctrl_reg[dly_seq_pkg::CTRL_EN] && main_hit) begin
					if (mode == dly_seq_pkg::MODE_RUN || sub == dly_seq_pkg::SUB_TIME) begin
						state_next = dly_seq_pkg::ST_DELAY; // [R1] [R2] [R4]
					end else begin
						state_next = dly_seq_pkg::ST_COUNT; // [R3] [R5] [R6]
					end
				end
			end
			dly_seq_pkg::ST_DELAY: begin
				if (time_up) begin
					if (mode == dly_seq_pkg::MODE_TRIG && sub == dly_seq_pkg::SUB_TIME) begin
						state_next = dly_seq_pkg::ST_ARMED; // [R4]
					end else begin
						state_next = dly_seq_pkg::ST_POST; // [R2] [R6]
					end
				end
			end
			dly_seq_pkg::ST_COUNT: begin
				if (evts_up) begin
					if (sub == dly_seq_pkg::SUB_EVTIME) begin
						state_next = dly_seq_pkg::ST_DELAY; // [R6]
					end else begin
						state_next = dly_seq_pkg::ST_POST; // [R5]
					end
				end
			end
			dly_seq_pkg::ST_ARMED: begin
				if (dly_hit) begin
					state_next = dly_seq_pkg::ST_POST; // [R4]
				end
			end
			dly_seq_pkg::ST_POST: begin
				if (post_up) begin
					state_next = dly_seq_pkg::ST_IDLE; // [R17]
				end
			end
			default: state_next = dly_seq_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) state_reg <= dly_seq_pkg::ST_IDLE;
		else        state_reg <= state_next;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tcnt_reg <= 32'h0;
		end else if (state_reg == dly_seq_pkg::ST_DELAY && !time_up) begin
			tcnt_reg <= tcnt_reg + 32'h1;
		end else begin
			tcnt_reg <= 32'h0; // [R17]
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ecnt_reg <= 16'h0;
		end else if (state_reg == dly_seq_pkg::ST_COUNT) begin
			if (dly_hit) ecnt_reg <= ecnt_reg + 16'h1; // [R5]
		end else begin
			ecnt_reg <= 16'h0; // [R17]
		end
	end

	// The trigger point is remembered so software can find it in the record.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pcnt_reg     <= 5'h0;
			trig_idx_reg <= 4'h0;
		end else if (state_reg == dly_seq_pkg::ST_POST) begin
			pcnt_reg <= pcnt_reg + 5'h1; // [R8]
		end else begin
			pcnt_reg <= 5'h0;
			if (state_next == dly_seq_pkg::ST_POST) trig_idx_reg <= wp_reg;
		end
	end

	// A finished record is frozen so the live ring may keep running.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			record_done   <= 1'b0;
			shown_idx_reg <= 4'h0;
			for (int k = 0; k < dly_seq_pkg::REC_DEPTH; k++) disp_reg[k] <= 4'h0;
		end else begin
			record_done <= state_reg == dly_seq_pkg::ST_POST && post_up; // [R8]
			if (state_reg == dly_seq_pkg::ST_POST && post_up) begin
				shown_idx_reg <= trig_idx_reg;
				for (int k = 0; k < dly_seq_pkg::REC_DEPTH; k++) disp_reg[k] <= mem_reg[k];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) acquiring <= 1'b0;
		else        acquiring <= state_next == dly_seq_pkg::ST_POST;
	end

	// ----------------------------------------------------------------
	// Display hints
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			zone_start <= 32'h0;
			zone_end   <= 32'h0;
		end else begin
			zone_start <= delay_reg; // [R12] [R13]
			if (mode == dly_seq_pkg::MODE_RUN) begin
				zone_end <= delay_reg + 32'(dly_seq_pkg::REC_DEPTH); // [R12]
			end else begin
				zone_end <= dly_seq_pkg::MAIN_REC_END; // [R13]
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			main_bar_on    <= 1'b0;
			dly_bar_on     <= 1'b0;
			main_bar_level <= 8'h0;
			dly_bar_level  <= 8'h0;
		end else begin
			main_bar_on    <= 1'b1;
			dly_bar_on     <= mode == dly_seq_pkg::MODE_TRIG &&
				ctrl_reg[dly_seq_pkg::CTRL_DTYPE +: 3] <= 3'(dly_seq_pkg::TT_PULSE); // [R15]
			main_bar_level <= thresh_reg[mcfg_reg.source*8 +: 8]; // [R10]
			dly_bar_level  <= thresh_reg[dcfg_reg.source*8 +: 8]; // [R10]
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg   <= dly_seq_pkg::CTRL_RST;
			delay_reg  <= dly_seq_pkg::DELAY_RST;
			events_reg <= dly_seq_pkg::EVENTS_RST;
			thresh_reg <= dly_seq_pkg::THRESH_RST;
			mcfg_reg   <= '0;
			dcfg_reg   <= '0;
			post_reg   <= dly_seq_pkg::POST_RST;
			ridx_reg   <= 4'h0;
		end else if (wr_en) begin
			unique case (addr)
				dly_seq_pkg::OFF_CTRL:   ctrl_reg   <= wr_data;
				dly_seq_pkg::OFF_DELAY:  delay_reg  <= wr_data; // [R14]
				dly_seq_pkg::OFF_EVENTS: events_reg <= wr_data[15:0]; // [R14]
				dly_seq_pkg::OFF_THRESH: thresh_reg <= wr_data; // [R10]
				dly_seq_pkg::OFF_MCFG:   mcfg_reg   <= wr_data[11:0]; // [R11]
				dly_seq_pkg::OFF_DCFG:   dcfg_reg   <= wr_data[11:0]; // [R11]
				dly_seq_pkg::OFF_POST:   post_reg   <= wr_data[4:0];
				dly_seq_pkg::OFF_RIDX:   ridx_reg   <= wr_data[3:0];
				default: ;
			endcase
		end
	end

	// A completion in the clearing cycle wins, so no record goes unseen.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			done_reg <= 1'b0;
		end else if (state_reg == dly_seq_pkg::ST_POST && post_up) begin
			done_reg <= 1'b1; // [R8]
		end else if (wr_en && addr == dly_seq_pkg::OFF_STATUS &&
			wr_data[dly_seq_pkg::STAT_DONE]) begin
			done_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= 32'h0;
		end else if (rd_en) begin
			unique case (addr)
				dly_seq_pkg::OFF_CTRL:   rd_data <= ctrl_reg;
				dly_seq_pkg::OFF_DELAY:  rd_data <= delay_reg;
				dly_seq_pkg::OFF_EVENTS: rd_data <= {16'h0, events_reg};
				dly_seq_pkg::OFF_THRESH: rd_data <= thresh_reg;
				dly_seq_pkg::OFF_MCFG:   rd_data <= {20'h0, mcfg_reg};
				dly_seq_pkg::OFF_DCFG:   rd_data <= {20'h0, dcfg_reg};
				dly_seq_pkg::OFF_STATUS: rd_data <= {ecnt_reg, 9'h0, state_reg,
					3'h0, done_reg};
				dly_seq_pkg::OFF_POST:   rd_data <= {27'h0, post_reg};
				dly_seq_pkg::OFF_RIDX:   rd_data <= {28'h0, ridx_reg};
				dly_seq_pkg::OFF_RDATA:  rd_data <= {20'h0, shown_idx_reg, 4'h0,
					disp_reg[ridx_reg]};
				default:                 rd_data <= 32'h0;
			endcase
		end else begin
			rd_data <= 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_delay_done;
		state_reg == dly_seq_pkg::ST_DELAY && time_up;
	endsequence

	sequence s_post_done;
		state_reg == dly_seq_pkg::ST_POST && post_up;
	endsequence

	property p_run_acquires;
		@(posedge clock) disable iff (!rst_b)
		s_delay_done and (mode == dly_seq_pkg::MODE_RUN) |=> state_reg == dly_seq_pkg::ST_POST;
	endproperty
	a_run_acquires: assert property (p_run_acquires) else $error("run mode did not acquire"); // [R2]

	property p_time_arms;
		@(posedge clock) disable iff (!rst_b)
		s_delay_done and (mode == dly_seq_pkg::MODE_TRIG && sub == dly_seq_pkg::SUB_TIME)
		|=> state_reg == dly_seq_pkg::ST_ARMED;
	endproperty
	a_time_arms: assert property (p_time_arms) else $error("after-time did not arm"); // [R4]

	property p_armed_hit;
		@(posedge clock) disable iff (!rst_b)
		state_reg == dly_seq_pkg::ST_ARMED && dly_hit |=> acquiring;
	endproperty
	a_armed_hit: assert property (p_armed_hit) else $error("armed hit not taken"); // [R4]

	property p_events_go;
		@(posedge clock) disable iff (!rst_b)
		state_reg == dly_seq_pkg::ST_COUNT && evts_up && sub == dly_seq_pkg::SUB_EVENTS
		|=> state_reg == dly_seq_pkg::ST_POST;
	endproperty
	a_events_go: assert property (p_events_go) else $error("event count ignored"); // [R5]

	property p_evtime;
		@(posedge clock) disable iff (!rst_b)
		state_reg == dly_seq_pkg::ST_COUNT && evts_up && sub == dly_seq_pkg::SUB_EVTIME
		|=> state_reg == dly_seq_pkg::ST_DELAY && tcnt_reg == 32'h0;
	endproperty
	a_evtime: assert property (p_evtime) else $error("events-then-time wrong"); // [R6]

	property p_done;
		@(posedge clock) disable iff (!rst_b)
		s_post_done |=> record_done && done_reg && state_reg == dly_seq_pkg::ST_IDLE
		&& ecnt_reg == 16'h0 && tcnt_reg == 32'h0;
	endproperty
	a_done: assert property (p_done) else $error("record not completed"); // [R8] [R17]

	// The edge that releases reset still holds the pointer, so it is not compared.
	property p_ring;
		@(posedge clock) disable iff (!rst_b)
		$past(rst_b) |-> wp_reg == $past(wp_reg) + 4'h1;
	endproperty
	a_ring: assert property (p_ring) else $error("pretrigger ring stalled"); // [R7]

	property p_zone;
		@(posedge clock) disable iff (!rst_b)
		mode == dly_seq_pkg::MODE_TRIG ##1 $stable(ctrl_reg) |-> zone_end == dly_seq_pkg::MAIN_REC_END;
	endproperty
	a_zone: assert property (p_zone) else $error("triggerable zone end wrong"); // [R13]

	property p_shared;
		@(posedge clock) disable iff (!rst_b)
		mcfg_reg.source == dcfg_reg.source ##1 $stable(mcfg_reg) && $stable(dcfg_reg)
		|-> main_bar_level == dly_bar_level;
	endproperty
	a_shared: assert property (p_shared) else $error("threshold not shared"); // [R10]

endmodule

// [hw/dly_seq_pkg.sv]
// Notes on behaviour
// R1: Two delay modes; only triggerable uses delayed system.
// R2: Run-after-main: main trigger, delay, then acquire.
// R3: Triggerable picks one of three qualification submodes.
// R4: After-time: delay, next delayed event, acquire.
// R5: After-events: count delayed events, then acquire.
// R6: Events-then-time: count events, delay, then acquire.
// R7: Pretrigger sampling runs continuously regardless.
// R8: Capture posttrigger samples, then present record.
// R9: Both systems offer five types, chosen independently.
// R10: One threshold per source, shared by both.
// R11: Slope, polarity, patterns separate per system.
// R12: Run-after-main zone spans the delayed record.
// R13: Triggerable zone runs to main record end.
// R14: Delay time and event count stored separately.
// R15: Edge or pulse triggerable shows two level bars.
// R16: Software configures main and delayed events first.
// R17: After a record, clear counters and rearm.
package dly_seq_pkg;

	// ----------------------------------------------------------------
	// Sizes and register map
	// ----------------------------------------------------------------
	localparam int N_SRC        = 4;
	localparam int SAMP_W       = 8;
	localparam int REC_DEPTH    = 16;
	localparam int IDX_W        = 4;
	localparam logic [31:0] MAIN_REC_END = 32'h0000_0400;

	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_DELAY  = 8'h04;
	localparam logic [7:0] OFF_EVENTS = 8'h08;
	localparam logic [7:0] OFF_THRESH = 8'h0C;
	localparam logic [7:0] OFF_MCFG   = 8'h10;
	localparam logic [7:0] OFF_DCFG   = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_POST   = 8'h1C;
	localparam logic [7:0] OFF_RIDX   = 8'h20;
	localparam logic [7:0] OFF_RDATA  = 8'h24;

	localparam int CTRL_EN    = 0;
	localparam int CTRL_MODE  = 1;
	localparam int CTRL_SUB   = 2;
	localparam int CTRL_MTYPE = 4;
	localparam int CTRL_DTYPE = 7;
	localparam int STAT_DONE  = 0;

	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] DELAY_RST  = 32'h0000_0010;
	localparam logic [15:0] EVENTS_RST = 16'h0001;
	localparam logic [31:0] THRESH_RST = 32'h8080_8080;
	localparam logic [4:0]  POST_RST   = 5'h08;

	typedef enum logic [2:0] {
		TT_EDGE    = 3'h0,
		TT_PULSE   = 3'h1,
		TT_PATTERN = 3'h2,
		TT_STATE   = 3'h3,
		TT_SEQ     = 3'h4
	} trig_type_t;

	localparam logic       MODE_RUN   = 1'h0;
	localparam logic       MODE_TRIG  = 1'h1;
	localparam logic [1:0] SUB_TIME   = 2'h0;
	localparam logic [1:0] SUB_EVENTS = 2'h1;
	localparam logic [1:0] SUB_EVTIME = 2'h2;

	// Per-system settings; thresholds are deliberately not in here.
	typedef struct packed {
		logic [3:0] mask;
		logic [3:0] pattern;
		logic       polarity;
		logic       slope;
		logic [1:0] source;
	} trig_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_DELAY = 3'h1,
		ST_COUNT = 3'h2,
		ST_ARMED = 3'h3,
		ST_POST  = 3'h4
	} seq_state_t;

endpackage

// [tb/probe_source.sv]
module probe_source (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [3:0]  fire,
	output logic      [31:0] samples
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] hold_reg [4];

	// ----------------------------------------------------------------
	// Probed inputs
	// ----------------------------------------------------------------
	// A request gives one full swing above and back below any nonzero threshold, so it counts
	// as exactly one event whatever slope the trigger system is set to.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			samples <= 32'h0000_0000;
			for (int i = 0; i < 4; i++) begin
				hold_reg[i] <= 2'h0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (fire[i]) begin
					hold_reg[i] <= 2'h3;
				end else if (hold_reg[i] != 2'h0) begin
					hold_reg[i] <= hold_reg[i] - 2'h1;
				end
				samples[8*i +: 8] <= (fire[i] || hold_reg[i] > 2'h1) ? 8'hFF : 8'h00;
			end
		end
	end
endmodule

// [tb/tb_delayed_trigger_sequencer.sv]
module tb_delayed_trigger_sequencer;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] v;
	} row_t;

	logic        clock;
	logic        rst_b;
	logic [31:0] samples;
	logic [7:0]  addr;
	logic [31:0] wr_data;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rd_data;
	logic        acquiring;
	logic        record_done;
	logic [31:0] zone_start;
	logic [31:0] zone_end;
	logic        main_bar_on;
	logic        dly_bar_on;
	logic [7:0]  main_bar_level;
	logic [7:0]  dly_bar_level;
	logic [3:0]  fire;
	logic [31:0] d;
	logic [3:0]  ti;
	int          err_total;
	int          checks_done;
	int          cycles;
	int          l1;
	int          l2;
	row_t        rows [7];

	dly_seq u_dut (.clock(clock), .rst_b(rst_b), .samples(samples), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.acquiring(acquiring), .record_done(record_done), .zone_start(zone_start),
		.zone_end(zone_end), .main_bar_on(main_bar_on), .dly_bar_on(dly_bar_on),
		.main_bar_level(main_bar_level), .dly_bar_level(dly_bar_level));

	probe_source u_src (.clock(clock), .rst_b(rst_b), .fire(fire), .samples(samples));

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// The whole run needs several hundred cycles; a hung wait is cut off well above that.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		addr    <= a;
		wr_data <= v;
		wr_en   <= 1'b1;
		@(posedge clock);
		wr_en   <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		v = rd_data;
	endtask

	task automatic settle();
		repeat (3) @(posedge clock);
		#1;
	endtask

	function automatic logic [31:0] ctrl_word(logic mode, logic [1:0] sub, logic [2:0] dt);
		return {22'h0, dt, 3'h0, sub, mode, 1'b1};
	endfunction

	task automatic fire_src(input logic [3:0] w);
		@(posedge clock);
		fire <= w;
		@(posedge clock);
		fire <= 4'h0;
	endtask

	// Any acquisition during the wait is a premature start.
	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clock);
			#1;
			if (acquiring === 1'b1) seen = 1'b1;
		end
		chk("early_acquire", 32'h0, {31'h0, seen});
	endtask

	// The pipeline latency is unknown but fixed, so only differences of it are compared.
	task automatic lat(input logic [3:0] w, output int n);
		fire_src(w);
		n = 0;
		#1;
		while (acquiring !== 1'b1 && n < 300) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("acquire_start", 32'h1, {31'h0, acquiring});
	endtask

	task automatic rec_end();
		int c;
		c = 0;
		while (acquiring === 1'b1 && c < 100) begin
			@(posedge clock);
			#1;
			c++;
		end
		chk("post_len", 32'h5, 32'(c));
		chk("record_done", 32'h1, {31'h0, record_done});
		rd(dly_seq_pkg::OFF_STATUS, d);
		chk("done_flag", 32'h1, {31'h0, d[0]});
		chk("state_idle", 32'h0, {29'h0, d[6:4]});
		chk("count_clear", 32'h0, {16'h0, d[31:16]});
		wr(dly_seq_pkg::OFF_STATUS, 32'h0000_0001);
		rd(dly_seq_pkg::OFF_STATUS, d);
		chk("done_clear", 32'h0, {31'h0, d[0]});
	endtask

	task automatic evtime_run(output int n);
		fire_src(4'h1);
		quiet(10);
		fire_src(4'h2);
		quiet(8);
		lat(4'h2, n);
		rec_end();
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_b = 1'b0; addr = 8'h00; wr_data = 32'h0; wr_en = 1'b0; rd_en = 1'b0;
		fire = 4'h0; err_total = 0; checks_done = 0; cycles = 0;
		rows[0] = '{dly_seq_pkg::OFF_CTRL, dly_seq_pkg::CTRL_RST};
		rows[1] = '{dly_seq_pkg::OFF_DELAY, dly_seq_pkg::DELAY_RST};
		rows[2] = '{dly_seq_pkg::OFF_EVENTS, {16'h0, dly_seq_pkg::EVENTS_RST}};
		rows[3] = '{dly_seq_pkg::OFF_THRESH, dly_seq_pkg::THRESH_RST};
		rows[4] = '{dly_seq_pkg::OFF_POST, {27'h0, dly_seq_pkg::POST_RST}};
		rows[5] = '{dly_seq_pkg::OFF_STATUS, 32'h0};
		rows[6] = '{8'h3C, 32'h0};
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a, d);
			chk("reset_value", rows[i].v, d);
		end
		chk("zone_start", 32'h10, zone_start);
		chk("zone_end", 32'h20, zone_end);
		chk("main_bar_on", 32'h1, {31'h0, main_bar_on});
		chk("main_level", 32'h80, {24'h0, main_bar_level});
		// Both systems on source 0 must read the same shared threshold.
		wr(dly_seq_pkg::OFF_MCFG, 32'h0000_0004);
		wr(dly_seq_pkg::OFF_DCFG, 32'h0000_0004);
		wr(dly_seq_pkg::OFF_THRESH, 32'h8080_8040);
		settle();
		chk("shared_main", 32'h40, {24'h0, main_bar_level});
		chk("shared_dly", 32'h40, {24'h0, dly_bar_level});
		wr(dly_seq_pkg::OFF_DCFG, 32'h0000_0005);
		wr(dly_seq_pkg::OFF_THRESH, 32'h8080_9040);
		wr(dly_seq_pkg::OFF_POST, 32'h0000_0005);
		settle();
		chk("split_main", 32'h40, {24'h0, main_bar_level});
		chk("split_dly", 32'h90, {24'h0, dly_bar_level});
		for (int t = 0; t < 5; t++) begin
			wr(dly_seq_pkg::OFF_CTRL, ctrl_word(1'b1, dly_seq_pkg::SUB_TIME, 3'(t)));
			settle();
			chk("dly_bar_on", {31'h0, t < 2}, {31'h0, dly_bar_on});
		end
		// Run-after-main: the delayed system alone must never start a capture.
		wr(dly_seq_pkg::OFF_DELAY, 32'h4);
		wr(dly_seq_pkg::OFF_CTRL, ctrl_word(1'b0, dly_seq_pkg::SUB_TIME, 3'h0));
		settle();
		chk("run_bar_off", 32'h0, {31'h0, dly_bar_on});
		chk("run_zone_end", 32'h14, zone_end);
		fire_src(4'h2);
		quiet(20);
		lat(4'h1, l1);
		rec_end();
		wr(dly_seq_pkg::OFF_DELAY, 32'hC);
		settle();
		chk("run_zone_start", 32'hC, zone_start);
		lat(4'h1, l2);
		rec_end();
		chk("run_delay_step", 32'h8, 32'(l2 - l1));
		// After-time: an event inside the delay must be ignored.
		wr(dly_seq_pkg::OFF_DELAY, 32'h28);
		wr(dly_seq_pkg::OFF_CTRL, ctrl_word(1'b1, dly_seq_pkg::SUB_TIME, 3'h0));
		settle();
		chk("trig_zone_end", 32'h400, zone_end);
		chk("trig_zone_start", 32'h28, zone_start);
		fire_src(4'h1);
		repeat (6) @(posedge clock);
		fire_src(4'h2);
		quiet(60);
		lat(4'h2, l1);
		rec_end();
		// After-events: two of three events leave it counting.
		wr(dly_seq_pkg::OFF_EVENTS, 32'h3);
		wr(dly_seq_pkg::OFF_CTRL, ctrl_word(1'b1, dly_seq_pkg::SUB_EVENTS, 3'h0));
		fire_src(4'h1);
		quiet(10);
		repeat (2) begin
			fire_src(4'h2);
			quiet(8);
		end
		rd(dly_seq_pkg::OFF_STATUS, d);
		chk("event_count", 32'h2, {16'h0, d[31:16]});
		chk("count_state", 32'h2, {29'h0, d[6:4]});
		lat(4'h2, l1);
		rec_end();
		// The frozen record holds the delayed event at its trigger point, quiet before it.
		rd(dly_seq_pkg::OFF_RDATA, d);
		ti = d[11:8];
		wr(dly_seq_pkg::OFF_RIDX, {28'h0, ti});
		rd(dly_seq_pkg::OFF_RDATA, d);
		chk("trig_sample", 32'h2, {28'h0, d[3:0]});
		wr(dly_seq_pkg::OFF_RIDX, {28'h0, ti - 4'h1});
		rd(dly_seq_pkg::OFF_RDATA, d);
		chk("pre_sample", 32'h0, {28'h0, d[3:0]});
		// Events-then-time: the delay still counts after the last event.
		wr(dly_seq_pkg::OFF_EVENTS, 32'h2);
		wr(dly_seq_pkg::OFF_DELAY, 32'h4);
		wr(dly_seq_pkg::OFF_CTRL, ctrl_word(1'b1, dly_seq_pkg::SUB_EVTIME, 3'h0));
		rd(dly_seq_pkg::OFF_EVENTS, d);
		chk("events_kept", 32'h2, d);
		evtime_run(l1);
		wr(dly_seq_pkg::OFF_DELAY, 32'hC);
		rd(dly_seq_pkg::OFF_EVENTS, d);
		chk("events_apart", 32'h2, d);
		evtime_run(l2);
		chk("evtime_step", 32'h8, 32'(l2 - l1));
		// A pattern main trigger starts a run capture; the delayed settings stay apart.
		wr(dly_seq_pkg::OFF_MCFG, 32'h0000_0114);
		wr(dly_seq_pkg::OFF_CTRL, ctrl_word(1'b0, dly_seq_pkg::SUB_TIME, 3'h0) | 32'h20);
		rd(dly_seq_pkg::OFF_DCFG, d);
		chk("dly_cfg_apart", 32'h5, d);
		lat(4'h1, l1);
		rec_end();
		// A reset in mid-delay must drop the capture and restore defaults.
		wr(dly_seq_pkg::OFF_CTRL, ctrl_word(1'b0, dly_seq_pkg::SUB_TIME, 3'h0));
		fire_src(4'h1);
		repeat (6) @(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		quiet(30);
		chk("reset_zone", 32'h10, zone_start);
		rd(dly_seq_pkg::OFF_CTRL, d);
		chk("reset_ctrl", 32'h0, d);
		rd(dly_seq_pkg::OFF_STATUS, d);
		chk("reset_status", 32'h0, d);
		conclude();
	end
endmodule
